// >>> logic/receive_payload_control.v
// receive payload conditioning stage with fifo and axi4-lite register slave
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`include "rx_payload_map.vh"

////////////////////////////////////////////////////////////////////////////////
module payload_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 8,
	parameter AW    = 3
)(
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW:0]      wr_q;
	reg  [AW:0]      rd_q;
	wire             full;
	wire             empty;

	// pointers carry one extra wrap bit
	assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[rd_q[AW-1:0]];

	// storage and pointer update
	always @(posedge aclk)
	begin
		if (in_valid && !full)
			mem[wr_q[AW-1:0]] <= in_data;
		if (!aresetn)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid && !full)
				wr_q <= wr_q + 1'b1;
			if (out_ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module receive_payload_control #(
	parameter FIFO_DEPTH = 8
)(
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	input  wire        rx_link_clk,
	input  wire        rx_serial_data_in,
	input  wire        rx_signaling_in,
	input  wire        rx_frame_pulse,
	input  wire        rx_multiframe_start,
	input  wire        prbs_pattern_bit,
	output reg         rx_serial_data_out,
	output reg         rx_signaling_out,
	output reg         prbs_extract_bit,
	output reg         prbs_extract_valid
);
	reg  [8:0]  cfg_q;
	reg  [6:0]  test_q;
	reg  [6:0]  acc_addr_q;
	reg         acc_rnw_q;
	reg  [7:0]  acc_data_q;
	reg         busy_q;
	reg  [1:0]  busy_cnt_q;
	reg         ovf_q;
	reg  [7:0]  ind_mem [0:127];
	reg  [3:0]  snap_mem [0:31];
	reg         aw_hold_q;
	reg         w_hold_q;
	reg  [7:0]  aw_addr_q;
	reg  [31:0] w_data_q;
	reg  [3:0]  w_strb_q;
	wire [5:0]  s2_q;
	reg  [2:0]  sig_in_sh_q;
	wire [63:0] alaw_w;
	wire [63:0] ulaw_w;
	wire [31:0] wmask;
	reg         clk_d_q;
	reg  [2:0]  bit_q;
	reg  [4:0]  slot_q;
	reg  [2:0]  mw_idx_q;
	reg         first_fr_q;
	reg  [6:0]  in_sh_q;
	reg  [6:0]  prbs_sh_q;
	reg  [6:0]  mask_sh_q;
	reg         push_q;
	reg  [11:0] push_data_q;
	reg  [7:0]  out_sh_q;
	reg  [7:0]  sig_sh_q;
	reg  [2:0]  out_cnt_q;
	reg         out_act_q;
	reg  [7:0]  data_d;
	reg  [3:0]  sig_d;
	reg  [7:0]  inv_m;
	reg  [3:0]  sig_s;
	wire        en;
	wire        t1;
	wire [1:0]  fmt;
	wire        rise;
	wire        fall;
	wire        fp;
	wire [2:0]  cur_bit;
	wire [4:0]  cur_slot;
	wire [7:0]  ctrl;
	wire [7:0]  dtrk;
	wire [7:0]  strk;
	wire [2:0]  sub;
	wire        tap_bit;
	wire        do_write;
	wire        fifo_ready;
	wire        fifo_valid;
	wire [11:0] fifo_data;
	wire        pop;
	wire [7:0]  byte_w;
	wire [3:0]  sig_in;

	// indirect address of a slot inside a window; t1 channels start at 1
	function [6:0] slot_addr;
		input [6:0] base;
		input [4:0] slot;
		input       is_t1;
		begin
			slot_addr = base + {2'b00, slot} + {6'h00, is_t1};
		end
	endfunction

	// bit mask of the byte lanes enabled by a write strobe
	function [31:0] strb_mask;
		input [3:0] s;
		begin
			strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel: address and data taken in either order
	assign awready  = ~aw_hold_q & ~bvalid;
	assign wready   = ~w_hold_q & ~bvalid;
	assign do_write = aw_hold_q & w_hold_q & ~bvalid;
	assign arready  = ~rvalid;
	assign wmask    = strb_mask(w_strb_q);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= 2'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_hold_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid    <= 1'b1;
				if (aw_addr_q == `RP_OFF_CFG || aw_addr_q == `RP_OFF_TEST ||
					aw_addr_q == `RP_OFF_ACC || aw_addr_q == `RP_OFF_DATA ||
					aw_addr_q == `RP_OFF_STAT)
					bresp <= 2'h0;
				else
					bresp <= 2'h2;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// register file, indirect access engine and overflow flag
	always @(posedge aclk)
	begin
		if (busy_q && busy_cnt_q == 2'h0 && !acc_rnw_q)
			ind_mem[acc_addr_q] <= acc_data_q;
		if (!aresetn)
		begin
			cfg_q      <= `RP_CFG_RST;
			test_q     <= `RP_TEST_RST;
			acc_addr_q <= 7'h00;
			acc_rnw_q  <= 1'b0;
			acc_data_q <= 8'h00;
			busy_q     <= 1'b0;
			busy_cnt_q <= 2'h0;
			ovf_q      <= 1'b0;
		end
		else
		begin
			if (do_write)
			begin
				if (aw_addr_q == `RP_OFF_CFG)
					cfg_q <= (cfg_q & ~wmask[8:0]) | (w_data_q[8:0] & wmask[8:0]);
				else if (aw_addr_q == `RP_OFF_TEST && w_strb_q[0])
					test_q <= w_data_q[6:0];
				else if (aw_addr_q == `RP_OFF_ACC && w_strb_q[0] && !busy_q)
				begin
					acc_addr_q <= w_data_q[6:0];
					acc_rnw_q  <= w_data_q[`RP_ACC_RNW];
					busy_q     <= 1'b1;
					busy_cnt_q <= `RP_ACC_CYC;
				end
				else if (aw_addr_q == `RP_OFF_DATA && w_strb_q[0] && !busy_q)
					acc_data_q <= w_data_q[7:0];
			end
			if (busy_q)
			begin
				if (busy_cnt_q == 2'h0)
				begin
					busy_q <= 1'b0;
					if (acc_rnw_q)
						acc_data_q <= ind_mem[acc_addr_q];
				end
				else
					busy_cnt_q <= busy_cnt_q - 2'h1;
			end
			// a drop in the same cycle as the clear keeps the flag set
			if (push_q && !fifo_ready)
				ovf_q <= 1'b1;
			else if (do_write && aw_addr_q == `RP_OFF_STAT && w_strb_q[0] && w_data_q[1])
				ovf_q <= 1'b0;
		end
	end

	// axi4-lite read channel
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= 2'h0;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rresp  <= 2'h0;
			if (araddr == `RP_OFF_CFG)
				rdata <= {23'h000000, cfg_q};
			else if (araddr == `RP_OFF_TEST)
				rdata <= {25'h0000000, test_q};
			else if (araddr == `RP_OFF_ACC)
				rdata <= {24'h000000, acc_rnw_q, acc_addr_q};
			else if (araddr == `RP_OFF_DATA)
				rdata <= {24'h000000, acc_data_q};
			else if (araddr == `RP_OFF_STAT)
				rdata <= {30'h00000000, ovf_q, busy_q};
			else
			begin
				rdata <= 32'h00000000;
				rresp <= 2'h2;
			end
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for the link pins
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1)
		begin : g_sync
			wire raw;
			reg  meta_q;
			reg  sync_q;
			assign raw = (gi == 0) ? rx_link_clk : (gi == 1) ? rx_serial_data_in :
				(gi == 2) ? rx_signaling_in : (gi == 3) ? rx_frame_pulse :
				(gi == 4) ? rx_multiframe_start : prbs_pattern_bit;
			// each bit has its own flops so every register has one driver
			assign s2_q[gi] = sync_q;
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end
				else
				begin
					meta_q <= raw;
					sync_q <= meta_q;
				end
			end
		end
	endgenerate

	assign en       = cfg_q[`RP_CFG_EN];
	assign t1       = ~test_q[`RP_TST_E1];
	assign fmt      = test_q[`RP_TST_FMT+1:`RP_TST_FMT];
	assign rise     = s2_q[0] & ~clk_d_q;
	assign fall     = ~s2_q[0] & clk_d_q;
	assign fp       = s2_q[3];
	assign cur_bit  = fp ? 3'h0 : bit_q;
	assign cur_slot = fp ? 5'h00 : slot_q;
	assign ctrl     = ind_mem[slot_addr(`RP_IA_CTRL, cur_slot, t1)];
	assign dtrk     = ind_mem[slot_addr(`RP_IA_DTRK, cur_slot, t1)];
	assign strk     = ind_mem[slot_addr(`RP_IA_STRK, cur_slot, t1)];
	assign byte_w   = {in_sh_q, s2_q[1]};
	assign sig_in   = {sig_in_sh_q, s2_q[2]};
	assign alaw_w   = `RP_ALAW >> {~mw_idx_q, 3'h0};
	assign ulaw_w   = `RP_ULAW >> {~mw_idx_q, 3'h0};
	assign sub      = (cfg_q[8:6] != `RP_SUB_NONE) ? cfg_q[8:6] : ctrl[2:0];

	// unframed takes every bit, framed modes only bits of test slots
	assign tap_bit  = (test_q[3:2] == `RP_MODE_UNF) |
		(ctrl[6] & ((test_q[3:2] == `RP_MODE_8B) |
		((test_q[3:2] == `RP_MODE_7B) & (cur_bit != 3'h7))));

	// byte processing in the documented order
	always @*
	begin
		data_d = byte_w;
		if (sub == `RP_SUB_TRK)
			data_d = dtrk;
		else if (sub == `RP_SUB_ALAW)
			data_d = alaw_w[7:0];
		else if (sub == `RP_SUB_ULAW)
			data_d = ulaw_w[7:0];
		inv_m = {ctrl[3] | ctrl[5], ctrl[4], ctrl[5], ctrl[4],
			ctrl[5], ctrl[4], ctrl[5], ctrl[4]};
		data_d = data_d ^ inv_m;
		if (test_q[`RP_TST_EN] && test_q[`RP_TST_DIR])
			data_d = (data_d & ~{mask_sh_q, tap_bit}) |
				({prbs_sh_q, s2_q[5]} & {mask_sh_q, tap_bit});
		sig_s = (cfg_q[`RP_CFG_SNAP] && !first_fr_q && !(t1 && fmt == `RP_FMT_DM)) ?
			snap_mem[cur_slot] : sig_in;
		sig_d = sig_s;
		if (t1 && (fmt == `RP_FMT_ESF || fmt == `RP_FMT_SLC) && !cfg_q[`RP_CFG_POS])
			sig_d = {sig_s[3:2], 2'b00};
		if (cfg_q[`RP_CFG_GSTRK] || strk[4])
			sig_d = strk[3:0];
		if (cfg_q[`RP_CFG_FORCE] && t1 && fmt != `RP_FMT_DM)
			sig_d = {4{cfg_q[`RP_CFG_LEVEL]}};
		if (!en)
		begin
			data_d = byte_w;
			sig_d  = sig_in;
		end
	end

	// link input side: bit and slot counting, tap and byte assembly
	always @(posedge aclk)
	begin
		if (rise && first_fr_q && bit_q == 3'h7)
			snap_mem[cur_slot] <= sig_in;
		if (!aresetn)
		begin
			clk_d_q            <= 1'b0;
			bit_q              <= 3'h0;
			slot_q             <= 5'h00;
			mw_idx_q           <= 3'h0;
			first_fr_q         <= 1'b0;
			in_sh_q            <= 7'h00;
			sig_in_sh_q        <= 3'h0;
			prbs_sh_q          <= 7'h00;
			mask_sh_q          <= 7'h00;
			push_q             <= 1'b0;
			push_data_q        <= 12'h000;
			prbs_extract_bit   <= 1'b0;
			prbs_extract_valid <= 1'b0;
		end
		else
		begin
			clk_d_q            <= s2_q[0];
			push_q             <= 1'b0;
			prbs_extract_valid <= 1'b0;
			if (rise)
			begin
				in_sh_q   <= {in_sh_q[5:0], s2_q[1]};
				sig_in_sh_q <= {sig_in_sh_q[1:0], s2_q[2]};
				prbs_sh_q <= {prbs_sh_q[5:0], s2_q[5]};
				mask_sh_q <= {mask_sh_q[5:0], tap_bit};
				if (fp)
				begin
					mw_idx_q   <= mw_idx_q + 3'h1;
					first_fr_q <= s2_q[4];
				end
				// prbs tap sees the raw received bit ahead of any change
				if (en && test_q[`RP_TST_EN] && !test_q[`RP_TST_DIR] && tap_bit)
				begin
					prbs_extract_bit   <= s2_q[1];
					prbs_extract_valid <= 1'b1;
				end
				bit_q <= cur_bit + 3'h1;
				if (cur_bit == 3'h7)
				begin
					slot_q      <= cur_slot + 5'h01;
					push_q      <= 1'b1;
					push_data_q <= {sig_d, data_d};
				end
				else
					slot_q <= cur_slot;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	payload_fifo #(
		.WIDTH (12),
		.DEPTH (FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (push_q),
		.in_ready  (fifo_ready),
		.in_data   (push_data_q),
		.out_valid (fifo_valid),
		.out_ready (pop),
		.out_data  (fifo_data)
	);

	// output side loads a byte at a byte boundary on a falling link edge
	assign pop = fall & ((out_cnt_q == 3'h7) | ~out_act_q) & fifo_valid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_sh_q           <= 8'hFF;
			sig_sh_q           <= 8'hFF;
			out_cnt_q          <= 3'h0;
			out_act_q          <= 1'b0;
			rx_serial_data_out <= 1'b1;
			rx_signaling_out   <= 1'b1;
		end
		else if (fall)
		begin
			if (pop)
			begin
				rx_serial_data_out <= fifo_data[7];
				rx_signaling_out   <= 1'b0;
				out_sh_q           <= {fifo_data[6:0], 1'b1};
				sig_sh_q           <= {3'h0, fifo_data[11:8], 1'b1};
				out_cnt_q          <= 3'h0;
				out_act_q          <= 1'b1;
			end
			else if (out_act_q && out_cnt_q != 3'h7)
			begin
				rx_serial_data_out <= out_sh_q[7];
				rx_signaling_out   <= sig_sh_q[7];
				out_sh_q           <= {out_sh_q[6:0], 1'b1};
				sig_sh_q           <= {sig_sh_q[6:0], 1'b1};
				out_cnt_q          <= out_cnt_q + 3'h1;
			end
			else
			begin
				out_act_q          <= 1'b0;
				rx_serial_data_out <= 1'b1;
				rx_signaling_out   <= 1'b1;
			end
		end
	end
endmodule

// >>> pkg/rx_payload_map.vh
// register map, field positions and constants of the receive payload stage
`ifndef RX_PAYLOAD_MAP_VH
`define RX_PAYLOAD_MAP_VH
`define RP_OFF_CFG    8'h00
`define RP_OFF_TEST   8'h04
`define RP_OFF_ACC    8'h08
`define RP_OFF_DATA   8'h0C
`define RP_OFF_STAT   8'h10
`define RP_CFG_RST    9'h000
`define RP_TEST_RST   7'h00
`define RP_CFG_EN     0
`define RP_CFG_FORCE  1
`define RP_CFG_LEVEL  2
`define RP_CFG_POS    3
`define RP_CFG_SNAP   4
`define RP_CFG_GSTRK  5
`define RP_CFG_GSUB   6
`define RP_TST_EN     0
`define RP_TST_DIR    1
`define RP_TST_MODE   2
`define RP_TST_E1     4
`define RP_TST_FMT    5
`define RP_ACC_RNW    7
`define RP_FMT_SF     2'h0
`define RP_FMT_ESF    2'h1
`define RP_FMT_SLC    2'h2
`define RP_FMT_DM     2'h3
`define RP_MODE_UNF   2'h0
`define RP_MODE_8B    2'h1
`define RP_MODE_7B    2'h2
`define RP_SUB_NONE   3'h0
`define RP_SUB_TRK    3'h1
`define RP_SUB_ALAW   3'h2
`define RP_SUB_ULAW   3'h3
`define RP_IA_CTRL    7'h00
`define RP_IA_DTRK    7'h20
`define RP_IA_STRK    7'h40
`define RP_ACC_CYC    2'h2
`define RP_ALAW       64'h34212134B4A1A1B4
`define RP_ULAW       64'h1E0B0B1E9E8B8B9E
`endif

// >>> bench/rx_payload_chk.sv
// port checker for the receive payload stage
`timescale 1ns/100ps
module rx_payload_chk (
	input wire        aclk,
	input wire        aresetn,
	input wire [7:0]  awaddr,
	input wire        awvalid,
	input wire        awready,
	input wire        wvalid,
	input wire        wready,
	input wire [1:0]  bresp,
	input wire        bvalid,
	input wire        bready,
	input wire [7:0]  araddr,
	input wire        arvalid,
	input wire        arready,
	input wire [31:0] rdata,
	input wire [1:0]  rresp,
	input wire        rvalid,
	input wire        rready,
	input wire        rx_link_clk,
	input wire        prbs_extract_valid
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// address and data taken at the same edge
	wire aw_w = awvalid && awready && wvalid && wready;

	property p_b_after;
		aw_w |=> !awready && !wready ##1 bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write answer late");
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_b_bad;
		aw_w && awaddr > 8'h10 |=> ##1 bvalid && bresp == 2'b10;
	endproperty
	a_b_bad: assert property (p_b_bad) else $error("unmapped write accepted");
	property p_r_after;
		arvalid && arready |=> rvalid && !arready;
	endproperty
	a_r_after: assert property (p_r_after) else $error("read answer late");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data moved");
	property p_r_bad;
		arvalid && arready && araddr > 8'h10 |=> rdata == 32'h0 && rresp == 2'b10;
	endproperty
	a_r_bad: assert property (p_r_bad) else $error("unmapped read accepted");
	property p_ext_pulse;
		prbs_extract_valid |=> !prbs_extract_valid;
	endproperty
	a_ext_pulse: assert property (p_ext_pulse) else $error("tap strobe too long");
	property p_ext_when;
		prbs_extract_valid |-> $past(rx_link_clk, 2) || $past(rx_link_clk, 3);
	endproperty
	a_ext_when: assert property (p_ext_when) else $error("tap strobe off link rise");
endmodule

bind receive_payload_control rx_payload_chk u_chk (
	.aclk               (aclk),
	.aresetn            (aresetn),
	.awaddr             (awaddr),
	.awvalid            (awvalid),
	.awready            (awready),
	.wvalid             (wvalid),
	.wready             (wready),
	.bresp              (bresp),
	.bvalid             (bvalid),
	.bready             (bready),
	.araddr             (araddr),
	.arvalid            (arvalid),
	.arready            (arready),
	.rdata              (rdata),
	.rresp              (rresp),
	.rvalid             (rvalid),
	.rready             (rready),
	.rx_link_clk        (rx_link_clk),
	.prbs_extract_valid (prbs_extract_valid)
);

// >>> bench/rx_far_end.sv
// backplane model that samples the processed serial streams
`timescale 1ns/100ps
module rx_far_end (
	input wire       rx_link_clk,
	input wire       rx_serial_data_out,
	input wire       rx_signaling_out,
	output reg [7:0] data_hist,
	output reg [7:0] sig_hist
);
	// shift both streams in at link rise, oldest bit ends in bit 7
	always @(posedge rx_link_clk)
	begin
		data_hist <= {data_hist[6:0], rx_serial_data_out};
		sig_hist <= {sig_hist[6:0], rx_signaling_out};
	end
endmodule

// >>> bench/receive_payload_control_tb.sv
// testbench of the receive payload stage
`timescale 1ns/100ps
module receive_payload_control_tb;
	reg         aclk;
	reg         aresetn;
	reg  [7:0]  awaddr;
	reg         awvalid;
	reg  [31:0] wdata;
	reg         wvalid;
	reg         bready;
	reg  [7:0]  araddr;
	reg         arvalid;
	reg         rready;
	reg         rx_link_clk;
	reg         rx_serial_data_in;
	reg         rx_signaling_in;
	reg         rx_frame_pulse;
	reg         rx_multiframe_start;
	reg         prbs_pattern_bit;
	wire        awready;
	wire        wready;
	wire [1:0]  bresp;
	wire        bvalid;
	wire        arready;
	wire [31:0] rdata;
	wire [1:0]  rresp;
	wire        rvalid;
	wire        rx_serial_data_out;
	wire        rx_signaling_out;
	wire        prbs_extract_valid;
	wire        prbs_extract_bit;
	wire [7:0]  data_hist;
	wire [7:0]  sig_hist;
	integer     n_fail;
	integer     comparisons;
	integer     k;
	integer     f;
	reg  [6:0]  j;
	reg  [31:0] rv;
	reg  [1:0]  rr;

	receive_payload_control u_receive_payload_control (
		.aclk                (aclk),
		.aresetn             (aresetn),
		.awaddr              (awaddr),
		.awvalid             (awvalid),
		.awready             (awready),
		.wdata               (wdata),
		.wstrb               (4'hF),
		.wvalid              (wvalid),
		.wready              (wready),
		.bresp               (bresp),
		.bvalid              (bvalid),
		.bready              (bready),
		.araddr              (araddr),
		.arvalid             (arvalid),
		.arready             (arready),
		.rdata               (rdata),
		.rresp               (rresp),
		.rvalid              (rvalid),
		.rready              (rready),
		.rx_link_clk         (rx_link_clk),
		.rx_serial_data_in   (rx_serial_data_in),
		.rx_signaling_in     (rx_signaling_in),
		.rx_frame_pulse      (rx_frame_pulse),
		.rx_multiframe_start (rx_multiframe_start),
		.prbs_pattern_bit    (prbs_pattern_bit),
		.rx_serial_data_out  (rx_serial_data_out),
		.rx_signaling_out    (rx_signaling_out),
		.prbs_extract_bit    (prbs_extract_bit),
		.prbs_extract_valid  (prbs_extract_valid)
	);
	rx_far_end u_rx_far_end (
		.rx_link_clk(rx_link_clk),
		.rx_serial_data_out(rx_serial_data_out),
		.rx_signaling_out(rx_signaling_out),
		.data_hist(data_hist),
		.sig_hist(sig_hist)
	);

	// system clock and free running link clock
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	initial
	begin
		rx_link_clk = 1'b0;
		#7;
		forever #160 rx_link_clk = ~rx_link_clk;
	end

	// two-slot frames: data 0F then F0, signaling 0011 (0001 in a multiframe's first frame)
	initial
	begin
		f = 0;
		forever
		begin
			for (k = 0; k < 16; k = k + 1)
			begin
				@(negedge rx_link_clk);
				@(posedge aclk);
				rx_serial_data_in <= k[2] ^ k[3];
				rx_signaling_in <= k[2] & k[1] & (k[0] | (f % 4 != 0));
				rx_frame_pulse <= (k == 0);
				rx_multiframe_start <= (k == 0) && (f % 4 == 0);
			end
			f = f + 1;
		end
	end

	task chk(input [31:0] g, input [31:0] e);
	begin
		comparisons = comparisons + 1;
		if (g !== e)
		begin
			n_fail = n_fail + 1;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	end
	endtask

	// look for a byte in one stream once the pipeline has flushed
	task see(input s, input [7:0] e, input want);
		reg hit;
		integer i;
	begin
		hit = 1'b0;
		for (i = 0; i < 180; i = i + 1)
		begin
			@(negedge rx_link_clk);
			if (i > 24 && (s ? sig_hist : data_hist) === e)
				hit = 1'b1;
		end
		@(posedge aclk);
		comparisons = comparisons + 1;
		if (hit !== want)
		begin
			n_fail = n_fail + 1;
			$display("BAD %0t stream byte %h", $time, e);
		end
	end
	endtask

	// count tap strobes and tapped ones over one frame of 16 link bits
	task cnt(input [31:0] e, input [31:0] o);
		integer i;
		integer n;
		integer m;
	begin
		n = 0;
		m = 0;
		repeat (32) @(posedge aclk);
		for (i = 0; i < 128; i = i + 1)
		begin
			@(posedge aclk);
			if (prbs_extract_valid === 1'b1)
			begin
				n = n + 1;
				if (prbs_extract_bit === 1'b1)
					m = m + 1;
			end
		end
		chk(n, e);
		chk(m, o);
	end
	endtask

	// bus write, address and data offered together
	task wr(input [7:0] a, input [31:0] d);
	begin
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (awvalid || wvalid);
		while (bvalid !== 1'b1)
			@(posedge aclk);
		rr = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	end
	endtask

	task rd(input [7:0] a);
	begin
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
			@(posedge aclk);
		while (rvalid !== 1'b1);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	end
	endtask

	// indirect access, then wait for busy to clear
	task ia(input rnw, input [6:0] a, input [7:0] d);
	begin
		wr(8'h0C, {24'h0, d});
		wr(8'h08, {24'h0, rnw, a});
		rv = 32'h1;
		while (rv[0] !== 1'b0)
			rd(8'h10);
	end
	endtask

	task stop_test;
	begin
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask

	initial
	begin
		#3000000;
		n_fail = n_fail + 1;
		stop_test;
	end

	////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		n_fail = 0;
		comparisons = 0;
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		rx_serial_data_in = 1'b1;
		rx_signaling_in = 1'b1;
		rx_frame_pulse = 1'b0;
		rx_multiframe_start = 1'b0;
		prbs_pattern_bit = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h00);
		chk(rv, 32'h0);
		rd(8'h04);
		chk(rv, 32'h0);
		rd(8'h10);
		chk(rv, 32'h0);
		rd(8'h20);
		chk(rr, 2'b10);
		wr(8'h24, 32'hFF);
		chk(rr, 2'b10);
		// both slots: plain control, data code 3C, signaling code 9 unarmed
		for (j = 1; j < 3; j = j + 1)
		begin
			ia(1'b0, j, 8'h00);
			ia(1'b0, 7'h20 + j, 8'h3C);
			ia(1'b0, 7'h40 + j, 8'h09);
		end
		ia(1'b1, 7'h21, 8'h00);
		rd(8'h0C);
		chk(rv, 32'h3C);
		wr(8'h00, 32'h40);
		see(1'b0, 8'h3C, 1'b0);
		wr(8'h00, 32'h41);
		see(1'b0, 8'h3C, 1'b1);
		wr(8'h00, 32'hC1);
		see(1'b0, 8'h8B, 1'b1);
		wr(8'h00, 32'h81);
		see(1'b0, 8'hA1, 1'b1);
		wr(8'h00, 32'h141);
		see(1'b0, 8'hA1, 1'b0);
		wr(8'h00, 32'h01);
		ia(1'b0, 7'h01, 8'h19);
		see(1'b0, 8'hE9, 1'b1);
		ia(1'b0, 7'h01, 8'h21);
		see(1'b0, 8'h96, 1'b1);
		ia(1'b0, 7'h01, 8'h59);
		wr(8'h04, 32'h03);
		see(1'b0, 8'h00, 1'b1);
		wr(8'h04, 32'h07);
		see(1'b0, 8'hE9, 1'b0);
		see(1'b0, 8'hF0, 1'b1);
		wr(8'h04, 32'h01);
		cnt(16, 8);
		wr(8'h04, 32'h05);
		cnt(8, 4);
		wr(8'h04, 32'h09);
		cnt(7, 3);
		wr(8'h04, 32'h00);
		wr(8'h00, 32'h07);
		see(1'b1, 8'h0F, 1'b1);
		wr(8'h00, 32'h03);
		see(1'b1, 8'h00, 1'b1);
		wr(8'h00, 32'h21);
		see(1'b1, 8'h09, 1'b1);
		wr(8'h00, 32'h01);
		see(1'b1, 8'h09, 1'b0);
		ia(1'b0, 7'h41, 8'h19);
		see(1'b1, 8'h09, 1'b1);
		ia(1'b0, 7'h41, 8'h09);
		wr(8'h04, 32'h20);
		see(1'b1, 8'h03, 1'b0);
		wr(8'h00, 32'h09);
		see(1'b1, 8'h03, 1'b1);
		wr(8'h00, 32'h21);
		see(1'b1, 8'h09, 1'b1);
		wr(8'h04, 32'h00);
		wr(8'h00, 32'h11);
		see(1'b1, 8'h03, 1'b0);
		wr(8'h04, 32'h60);
		see(1'b1, 8'h03, 1'b1);
		stop_test;
	end
endmodule
